// ---- lse_cfg.svh ----
`ifndef LSE_CFG_SVH
`define LSE_CFG_SVH

// Address block geometry
`define LSE_BLOCKS 7
`define LSE_IN_PER_BLK 10
`define LSE_OUT_PER_BLK 6
`define LSE_IN_TERMS 70
`define LSE_OUT_TERMS 42

// Data table rows are the hundreds digit, columns the low two digits
`define LSE_ROWS 10
`define LSE_COLS 100
`define LSE_INT_ROW 4'h7
`define LSE_LAST_ROW 4'h9
`define LSE_LAST_COL 7'h63

// Offsets inside a block
`define LSE_IN_FIRST 7'h01
`define LSE_IN_LAST 7'h0a
`define LSE_OUT_FIRST 7'h0b
`define LSE_OUT_LAST 7'h10
`define LSE_RELAY_A 7'h11
`define LSE_RELAY_B 7'h12
`define LSE_FULL_INS 7'h0a
`define LSE_ANALOG_INS 7'h08
`define LSE_NO_INS 7'h00

// Fast counter and its sequencer steps
`define LSE_SQO_STEPS 4
`define LSE_SQO_W 2
`define LSE_HS_W 16

// Scan watchdog
`define LSE_WD_TIME_MS 100
`define LSE_CLK_HZ 50000000
`define LSE_MS_PER_S 1000

`endif

// ---- lse_pkg.sv ----
package lse_pkg;

  typedef enum logic [1:0] {
    LSE_OP_EXAM_ON,
    LSE_OP_EXAM_OFF,
    LSE_OP_ENERGIZE,
    LSE_OP_NOP
  } lse_op_type;

  typedef enum logic [1:0] {
    LSE_BLK_EMPTY,
    LSE_BLK_FULL,
    LSE_BLK_RELAY,
    LSE_BLK_ANALOG
  } lse_blk_type;

  typedef struct packed {
    lse_op_type op;
    logic [3:0] row;
    logic [6:0] col;
  } lse_instr_type;

  typedef enum logic [2:0] {
    LSE_ST_CAPTURE,
    LSE_ST_OUT,
    LSE_ST_IN,
    LSE_ST_PROG,
    LSE_ST_HALT
  } lse_state_type;

endpackage : lse_pkg

// ---- lse_sync.sv ----
module lse_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule : lse_sync

// ---- lse_watchdog.sv ----
module lse_watchdog #(
  parameter int LIMIT = 5000000
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic restart,
  input wire logic run,
  output logic trip
);

  logic [31:0] cnt_reg;
  logic trip_reg;

  // Trip latches until reset; the scan engine turns it into a shutdown
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cnt_reg <= 32'h0;
      trip_reg <= 1'b0;
    end else if (restart) begin
      cnt_reg <= 32'h0;
    end else if (run) begin
      cnt_reg <= cnt_reg + 32'h1;
      if (cnt_reg >= 32'(LIMIT)) begin
        trip_reg <= 1'b1;
      end
    end
  end

  assign trip = trip_reg;

endmodule : lse_watchdog

// ---- lse_scan_engine.sv ----
// Notes on behaviour
// RULE1 - Block n owns inputs (n-1)01..(n-1)10 and outputs (n-1)11..(n-1)16.
// RULE2 - Seven blocks at most, 112 external points; nothing past block seven.
// RULE3 - Larger processor fills blocks one and two with all their addresses.
// RULE4 - Relay unit uses outputs of two blocks; their inputs are skipped.
// RULE5 - Analog unit gives eight input bits; inputs 9, 10 and outputs skipped.
// RULE6 - Relay bits 17, 18 usable only in allocated blocks; block one always.
// RULE7 - Examine-on is true when its bit is on.
// RULE8 - Examine-off is true when its bit is off.
// RULE9 - Output-energize writes the rung continuity result into its bit.
// RULE10 - Input bit follows the voltage sensed at its terminal.
// RULE11 - Output contact closes while its bit is on, opens when off.
// RULE12 - I/O scan copies outputs first, then samples all inputs.
// RULE13 - Program scan runs each instruction once, in stored order.
// RULE14 - The last rung written for an address sets its final value.
// RULE15 - No terminal is sampled or driven during the program scan; code reads the pulse pin and drives outputs on pulses, test mode, shutdown.
// RULE16 - Fast pulses interrupt the scan and update sequencer outputs at once.
// RULE17 - A scan longer than 100 ms shuts the system down.
// RULE18 - A status bit holds 1 for on and 0 for off.
// RULE19 - Test mode runs the program with every output de-energized.
// RULE20 - Reset opens all outputs and starts with an I/O scan.
`include "lse_cfg.svh"

module lse_scan_engine #(
  parameter int PROG_DEPTH = 1200,
  parameter int AW = 11,
  parameter int WD_LIMIT = `LSE_WD_TIME_MS * (`LSE_CLK_HZ / `LSE_MS_PER_S)
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [`LSE_IN_TERMS-1:0] in_term,
  input wire lse_pkg::lse_blk_type [`LSE_BLOCKS-1:0] blk_cfg,
  input wire logic large_proc,
  input wire logic test_mode,
  input wire logic hsi_present,
  input wire logic high_speed_pulse_input,
  input wire logic [`LSE_HS_W-1:0] hs_preset,
  input wire logic [`LSE_SQO_STEPS-1:0][`LSE_OUT_PER_BLK-1:0] hs_pattern,
  input wire logic prog_we,
  input wire logic [AW-1:0] prog_addr,
  input wire lse_pkg::lse_instr_type prog_word,
  input wire logic [AW-1:0] prog_len,
  output logic [`LSE_OUT_TERMS-1:0] out_term,
  output logic sys_shutdown,
  output logic io_scan_active
);

  lse_pkg::lse_state_type state_reg;
  lse_pkg::lse_state_type state_next;

  lse_pkg::lse_instr_type prog_mem [0:PROG_DEPTH-1];
  logic [`LSE_COLS-1:0] dt_reg [0:`LSE_ROWS-1];

  lse_pkg::lse_blk_type [`LSE_BLOCKS-1:0] cfg_reg;
  logic large_reg;

  logic [AW-1:0] pc_reg;
  logic acc_reg;
  logic rung_open_reg;
  logic [`LSE_OUT_TERMS-1:0] out_term_reg;
  logic shutdown_reg;
  logic io_active_reg;

  logic [`LSE_HS_W-1:0] hs_cnt_reg;
  logic [`LSE_SQO_W-1:0] hs_step_reg;
  logic hs_prev_reg;

  logic [`LSE_IN_TERMS-1:0] in_sync;
  logic hs_sync;
  logic wd_trip;

  // Input terminals and fast pulse pin come from the field
  lse_sync #(
    .W(`LSE_IN_TERMS)
  ) u_in_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(in_term),
    .sync_out(in_sync)
  );

  lse_sync #(
    .W(1)
  ) u_hs_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(high_speed_pulse_input),
    .sync_out(hs_sync)
  );

  // Block map
  lse_pkg::lse_blk_type [`LSE_BLOCKS-1:0] blk_eff;
  logic [`LSE_BLOCKS-1:0] blk_alloc;
  logic [`LSE_BLOCKS-1:0] blk_out_ok;
  logic [`LSE_BLOCKS-1:0][6:0] blk_in_lim;
  logic [`LSE_OUT_TERMS-1:0] table_out;

  for (genvar b = 0; b < `LSE_BLOCKS; b++) begin : g_blk
    // RULE3 larger processor blocks
    assign blk_eff[b] = (b == 0 || (b == 1 && large_reg)) ? lse_pkg::LSE_BLK_FULL : cfg_reg[b];
    // RULE6 relay bits need allocation
    assign blk_alloc[b] = blk_eff[b] != lse_pkg::LSE_BLK_EMPTY;
    // RULE4 relay unit outputs only
    assign blk_out_ok[b] = blk_eff[b] == lse_pkg::LSE_BLK_FULL || blk_eff[b] == lse_pkg::LSE_BLK_RELAY;
    // RULE5 analog unit eight inputs
    assign blk_in_lim[b] = blk_eff[b] == lse_pkg::LSE_BLK_FULL ? `LSE_FULL_INS :
                           blk_eff[b] == lse_pkg::LSE_BLK_ANALOG ? `LSE_ANALOG_INS : `LSE_NO_INS;
    for (genvar j = 0; j < `LSE_OUT_PER_BLK; j++) begin : g_out
      // RULE1 output offsets of block
      assign table_out[b * `LSE_OUT_PER_BLK + j] = blk_out_ok[b] & dt_reg[b][int'(`LSE_OUT_FIRST) + j];
    end
  end

  // Current instruction and its address decode
  lse_pkg::lse_instr_type cur;
  logic [2:0] cur_blk;
  logic is_io_row;
  logic is_int_row;
  logic in_zone;
  logic out_zone;
  logic relay_zone;
  logic addr_ok;
  logic bit_val;
  logic cond_true;
  logic run_end;
  logic exec;
  logic is_cond;
  logic dt_we;

  assign cur = prog_mem[pc_reg];
  assign cur_blk = cur.row[2:0];
  // RULE2 only seven blocks exist
  assign is_io_row = cur.row < 4'(`LSE_BLOCKS);
  assign is_int_row = cur.row >= `LSE_INT_ROW && cur.row <= `LSE_LAST_ROW && cur.col <= `LSE_LAST_COL;
  // RULE1 input offsets of block
  assign in_zone = cur.col >= `LSE_IN_FIRST && cur.col <= blk_in_lim[cur_blk];
  assign out_zone = cur.col >= `LSE_OUT_FIRST && cur.col <= `LSE_OUT_LAST && blk_out_ok[cur_blk];
  // RULE6 relay bits per block
  assign relay_zone = (cur.col == `LSE_RELAY_A || cur.col == `LSE_RELAY_B) && blk_alloc[cur_blk];
  assign addr_ok = is_int_row || (is_io_row && (in_zone || out_zone || relay_zone));
  // RULE18 one means on
  assign bit_val = addr_ok & dt_reg[cur.row][cur.col];

  // RULE7 examine on
  // RULE8 examine off
  assign cond_true = cur.op == lse_pkg::LSE_OP_EXAM_ON ? bit_val : ~bit_val;
  assign is_cond = cur.op == lse_pkg::LSE_OP_EXAM_ON || cur.op == lse_pkg::LSE_OP_EXAM_OFF;

  // Fast pulse detection
  logic hs_pulse;
  logic hs_stall;
  logic hs_fire;
  logic [`LSE_HS_W-1:0] hs_cnt_inc;
  logic [`LSE_SQO_W-1:0] hs_step_next;
  logic [`LSE_OUT_PER_BLK-1:0] hs_out;

  assign hs_pulse = hs_sync & ~hs_prev_reg;
  // RULE16 pulse interrupts the scan
  assign hs_stall = hsi_present & hs_pulse;
  assign hs_cnt_inc = hs_cnt_reg + `LSE_HS_W'(1);
  assign hs_fire = hs_stall && hs_cnt_inc >= hs_preset;
  assign hs_step_next = hs_fire ? hs_step_reg + `LSE_SQO_W'(1) : hs_step_reg;
  assign hs_out = hs_pattern[hs_step_next];

  // RULE13 stored order, one pass
  assign run_end = pc_reg >= prog_len || pc_reg >= AW'(PROG_DEPTH);
  assign exec = state_reg == lse_pkg::LSE_ST_PROG && !run_end && !hs_stall;
  // RULE14 later rungs overwrite
  assign dt_we = exec && cur.op == lse_pkg::LSE_OP_ENERGIZE && addr_ok;

  // Scan sequence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      lse_pkg::LSE_ST_CAPTURE: state_next = lse_pkg::LSE_ST_OUT;
      // RULE12 outputs then inputs
      lse_pkg::LSE_ST_OUT: state_next = lse_pkg::LSE_ST_IN;
      lse_pkg::LSE_ST_IN: state_next = lse_pkg::LSE_ST_PROG;
      lse_pkg::LSE_ST_PROG: begin
        if (run_end) begin
          state_next = lse_pkg::LSE_ST_OUT;
        end
      end
      lse_pkg::LSE_ST_HALT: state_next = lse_pkg::LSE_ST_HALT;
      default: state_next = lse_pkg::LSE_ST_HALT;
    endcase
    if (hs_stall && state_reg != lse_pkg::LSE_ST_HALT) begin
      state_next = state_reg;
    end
    // RULE17 overrun halts
    if (wd_trip) begin
      state_next = lse_pkg::LSE_ST_HALT;
    end
  end

  // RULE17 scan timer
  lse_watchdog #(
    .LIMIT(WD_LIMIT)
  ) u_wd (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .restart(state_reg == lse_pkg::LSE_ST_OUT && !hs_stall),
    .run(state_reg != lse_pkg::LSE_ST_CAPTURE && state_reg != lse_pkg::LSE_ST_HALT),
    .trip(wd_trip)
  );

  // RULE20 reset starts with I/O scan
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_reg <= lse_pkg::LSE_ST_CAPTURE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Unit configuration is caught once after reset
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cfg_reg <= '0;
      large_reg <= 1'b0;
    end else if (state_reg == lse_pkg::LSE_ST_CAPTURE) begin
      cfg_reg <= blk_cfg;
      large_reg <= large_proc;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (prog_we && prog_addr < AW'(PROG_DEPTH)) begin
      prog_mem[prog_addr] <= prog_word;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pc_reg <= '0;
    end else if (state_reg == lse_pkg::LSE_ST_IN) begin
      pc_reg <= '0;
    end else if (exec) begin
      pc_reg <= pc_reg + AW'(1);
    end
  end

  // RULE9 rung continuity
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      acc_reg <= 1'b1;
      rung_open_reg <= 1'b0;
    end else if (state_reg == lse_pkg::LSE_ST_IN) begin
      acc_reg <= 1'b1;
      rung_open_reg <= 1'b0;
    end else if (exec && is_cond) begin
      acc_reg <= (rung_open_reg ? acc_reg : 1'b1) & cond_true;
      rung_open_reg <= 1'b1;
    end else if (exec && cur.op == lse_pkg::LSE_OP_ENERGIZE) begin
      rung_open_reg <= 1'b0;
    end
  end

  // Data table
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      for (int r = 0; r < `LSE_ROWS; r++) begin
        dt_reg[r] <= '0;
      end
    end else if (state_reg == lse_pkg::LSE_ST_IN) begin
      for (int b = 0; b < `LSE_BLOCKS; b++) begin
        for (int i = 0; i < `LSE_IN_PER_BLK; i++) begin
          // RULE10 input bit follows terminal
          dt_reg[b][i + int'(`LSE_IN_FIRST)] <= (7'(i) < blk_in_lim[b]) & in_sync[b * `LSE_IN_PER_BLK + i];
        end
      end
    end else if (dt_we) begin
      // RULE9 energize writes result
      dt_reg[cur.row][cur.col] <= acc_reg;
    end
  end

  // RULE16 fast count and step
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      hs_prev_reg <= 1'b0;
      hs_cnt_reg <= '0;
      hs_step_reg <= '0;
    end else begin
      hs_prev_reg <= hs_sync;
      if (hs_stall) begin
        hs_cnt_reg <= hs_fire ? '0 : hs_cnt_inc;
        hs_step_reg <= hs_step_next;
      end
    end
  end

  // Output terminals
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      out_term_reg <= '0;
    // RULE19 test mode de-energized
    end else if (shutdown_reg || wd_trip || test_mode) begin
      out_term_reg <= '0;
    end else begin
      // RULE15 data table copied to outputs only in I/O scan
      if (state_reg == lse_pkg::LSE_ST_OUT && !hs_stall) begin
        // RULE11 contact follows bit
        out_term_reg <= table_out;
        if (hsi_present) begin
          out_term_reg[`LSE_OUT_PER_BLK-1:0] <= hs_pattern[hs_step_reg];
        end
      end
      // RULE16 immediate sequencer outputs
      if (hs_stall) begin
        out_term_reg[`LSE_OUT_PER_BLK-1:0] <= hs_out;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      shutdown_reg <= 1'b0;
      io_active_reg <= 1'b1;
    end else begin
      // RULE17 shutdown latches
      if (wd_trip) begin
        shutdown_reg <= 1'b1;
      end
      io_active_reg <= state_next == lse_pkg::LSE_ST_OUT || state_next == lse_pkg::LSE_ST_IN;
    end
  end

  assign out_term = out_term_reg;
  assign sys_shutdown = shutdown_reg;
  assign io_scan_active = io_active_reg;

endmodule : lse_scan_engine

// ---- lse_scan_asserts.sv ----
`include "lse_cfg.svh"

module lse_scan_chk #(
  parameter int WD_LIMIT = 200
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic test_mode,
  input wire logic hsi_present,
  input wire logic [`LSE_OUT_TERMS-1:0] out_term,
  input wire logic sys_shutdown,
  input wire logic io_scan_active
);
  logic [15:0] low_cnt_reg;

  default clocking cb @(posedge ref_clk); endclocking

  // Cycles spent outside the I/O scan while still running
  always_ff @(posedge ref_clk) begin
    if (!rst_b || io_scan_active || sys_shutdown) begin
      low_cnt_reg <= 16'h0000;
    end else begin
      low_cnt_reg <= low_cnt_reg + 16'h0001;
    end
  end

  a_reset_open: assert property (!rst_b |=> out_term == '0 && io_scan_active && !sys_shutdown)
    else $error("outputs not open or no I/O scan after reset");
  a_test_dark: assert property (disable iff (!rst_b) test_mode ##1 test_mode |-> out_term == '0)
    else $error("output energized in test mode");
  a_halt_sticky: assert property (disable iff (!rst_b) sys_shutdown |=> sys_shutdown)
    else $error("shutdown released without reset");
  a_halt_dark: assert property (disable iff (!rst_b) sys_shutdown |-> out_term == '0)
    else $error("output energized during shutdown");
  a_out_at_io: assert property (disable iff (!rst_b) $changed(out_term) && !test_mode && !$past(test_mode)
    && !hsi_present && !$past(hsi_present) && !sys_shutdown |-> io_scan_active || $past(io_scan_active))
    else $error("outputs changed outside the I/O scan");
  a_io_pair: assert property (disable iff (!rst_b) $rose(io_scan_active) |=> io_scan_active)
    else $error("I/O scan shorter than two cycles");
  a_scan_recurs: assert property (disable iff (!rst_b)
    $fell(io_scan_active) |-> ##[1:300] (io_scan_active || sys_shutdown))
    else $error("no new I/O scan after the program scan");
  a_scan_bound: assert property (disable iff (!rst_b) int'(low_cnt_reg) <= WD_LIMIT + 8)
    else $error("overlong scan without shutdown");
endmodule : lse_scan_chk

bind lse_scan_engine lse_scan_chk #(.WD_LIMIT(WD_LIMIT)) lse_scan_chk_i (
  .ref_clk(ref_clk),
  .rst_b(rst_b),
  .test_mode(test_mode),
  .hsi_present(hsi_present),
  .out_term(out_term),
  .sys_shutdown(sys_shutdown),
  .io_scan_active(io_scan_active)
);

// ---- lse_field_model.sv ----
`include "lse_cfg.svh"

module lse_field_model (
  input wire logic [`LSE_IN_TERMS-1:0] sensor_closed,
  input wire logic [`LSE_OUT_TERMS-1:0] out_term,
  output logic [`LSE_IN_TERMS-1:0] in_term,
  output logic [`LSE_OUT_TERMS-1:0] actuator_on
);
  // closed contact puts voltage on its terminal
  assign in_term = sensor_closed;
  // closed output contact energizes the load
  assign actuator_on = out_term;
endmodule : lse_field_model

// ---- tb_ladder_scan_engine.sv ----
`include "lse_cfg.svh"

module tb_ladder_scan_engine;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N_INS = 39;
  // Code: op in bits 13:12, hundreds digit in 11:8, low digits in 6:0
  localparam logic [15:0] PROG [N_INS] = '{
    16'h0001, 16'h1002, 16'h200b, 16'h0003, 16'h200c, 16'h0004, 16'h200d, 16'h1004, 16'h200d,
    16'h0005, 16'h2701, 16'h0701, 16'h200e, 16'h0201, 16'h200f, 16'h1209, 16'h2010,
    16'h0101, 16'h210b, 16'h0101, 16'h2111, 16'h0111, 16'h210c, 16'h0006, 16'h230b,
    16'h0301, 16'h230c, 16'h0006, 16'h2511, 16'h0511, 16'h230d, 16'h0006, 16'h2011,
    16'h0011, 16'h230e, 16'h0601, 16'h260b, 16'h0006, 16'h220b};
  localparam logic [69:0] PATS [4] = '{70'h0, {70{1'b1}}, 70'h15_5555_5555_5555_5555, 70'h2a_aaaa_aaaa_aaaa_aaaa};
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [69:0] sensor_closed = '0;
  logic [69:0] in_term;
  logic [41:0] out_term;
  logic [41:0] actuator_on;
  lse_pkg::lse_blk_type [6:0] blk_cfg = '{lse_pkg::LSE_BLK_FULL, lse_pkg::LSE_BLK_EMPTY, lse_pkg::LSE_BLK_RELAY,
    lse_pkg::LSE_BLK_RELAY, lse_pkg::LSE_BLK_ANALOG, lse_pkg::LSE_BLK_EMPTY, lse_pkg::LSE_BLK_FULL};
  logic test_mode = 1'b0;
  logic large_proc = 1'b1;
  logic hsi_present = 1'b0;
  logic high_speed_pulse_input = 1'b0;
  logic [15:0] hs_preset = 16'h0002;
  logic [3:0][5:0] hs_pattern = {6'h0c, 6'h2a, 6'h15, 6'h33};
  logic prog_we = 1'b0;
  logic [10:0] prog_addr = 11'h000;
  logic [10:0] prog_len = 11'h027;
  lse_pkg::lse_instr_type prog_word = '0;
  logic sys_shutdown;
  logic io_scan_active;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;

  lse_scan_engine #(.WD_LIMIT(200)) lse_scan_engine_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .in_term(in_term), .blk_cfg(blk_cfg), .large_proc(large_proc),
    .test_mode(test_mode), .hsi_present(hsi_present), .high_speed_pulse_input(high_speed_pulse_input),
    .hs_preset(hs_preset), .hs_pattern(hs_pattern), .prog_we(prog_we), .prog_addr(prog_addr),
    .prog_word(prog_word), .prog_len(prog_len), .out_term(out_term), .sys_shutdown(sys_shutdown),
    .io_scan_active(io_scan_active));
  lse_field_model lse_field_model_i (.sensor_closed(sensor_closed), .out_term(out_term), .in_term(in_term),
    .actuator_on(actuator_on));

  always #10 ref_clk = ~ref_clk;

  task print_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end

  task check(input logic [41:0] seen, input logic [41:0] want, input string what);
    check_count++;
    if (seen !== want) begin
      failures++;
      $display("BAD t=%0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check

  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task wait_io(input logic lvl);
    int k;
    k = 0;
    while (io_scan_active !== lvl && k < 600) begin
      tick(1);
      k++;
    end
  endtask : wait_io

  task settle;
    for (int i = 0; i < 3; i++) begin
      wait_io(1'b0);
      wait_io(1'b1);
    end
    tick(4);
  endtask : settle

  task pulse;
    high_speed_pulse_input = 1'b1;
    tick(3);
    high_speed_pulse_input = 1'b0;
    tick(3);
  endtask : pulse

  function logic [41:0] expect_out(input logic [69:0] s);
    logic [41:0] e;
    e = '0;
    e[0] = s[0] & ~s[1];
    e[1] = s[2];
    e[2] = ~s[3];
    e[3] = s[4];
    e[4] = s[20];
    e[5] = 1'b1;
    e[6] = s[10];
    e[7] = s[10];
    e[18] = s[5];
    e[21] = s[5];
    e[36] = s[60];
    return e;
  endfunction : expect_out

  task do_reset;
    rst_b = 1'b0;
    tick(2);
    rst_b = 1'b1;
    tick(1);
    check(out_term, '0, "out at reset");
    check({41'h0, io_scan_active}, 42'h1, "io at reset");
  endtask : do_reset

  task t_logic;
    for (int p = 0; p < 4; p++) begin
      sensor_closed = PATS[p];
      settle();
      check(out_term, expect_out(PATS[p]), "ladder");
      check(actuator_on, expect_out(PATS[p]), "loads");
    end
    $display("logic test done");
  endtask : t_logic

  task t_hold;
    sensor_closed = PATS[1];
    settle();
    wait_io(1'b0);
    sensor_closed = PATS[0];
    tick(10);
    check(out_term, expect_out(PATS[1]), "held");
    settle();
    check(out_term, expect_out(PATS[0]), "next io");
    $display("hold test done");
  endtask : t_hold

  task t_test_mode;
    sensor_closed = PATS[1];
    test_mode = 1'b1;
    settle();
    check(out_term, '0, "test dark");
    test_mode = 1'b0;
    settle();
    check(out_term, expect_out(PATS[1]), "test off");
    $display("test mode done");
  endtask : t_test_mode

  task t_fast;
    hsi_present = 1'b1;
    settle();
    check({36'h0, out_term[5:0]}, 42'h33, "step0");
    pulse();
    pulse();
    check({36'h0, out_term[5:0]}, 42'h15, "step1");
    hsi_present = 1'b0;
    pulse();
    settle();
    check(out_term, expect_out(PATS[1]), "no fast");
    $display("fast test done");
  endtask : t_fast

  task t_watchdog;
    int k;
    k = 0;
    prog_len = 11'd300;
    while (sys_shutdown !== 1'b1 && k < 1000) begin
      tick(1);
      k++;
    end
    tick(20);
    check({41'h0, sys_shutdown}, 42'h1, "halt");
    check(out_term, '0, "halt dark");
    prog_len = 11'h027;
    do_reset();
    settle();
    check(out_term, expect_out(PATS[1]), "rerun");
    $display("watchdog test done");
  endtask : t_watchdog

  // Smaller processor: block two follows its configured unit, which is empty here
  task t_small;
    large_proc = 1'b0;
    do_reset();
    settle();
    check(out_term, expect_out(PATS[1]) & ~42'h00_0000_00c0, "small");
    large_proc = 1'b1;
    do_reset();
    settle();
    check(out_term, expect_out(PATS[1]), "large again");
    $display("small test done");
  endtask : t_small

  initial begin
    tick(1);
    for (int i = 0; i < N_INS; i++) begin
      prog_we = 1'b1;
      prog_addr = 11'(i);
      prog_word = lse_pkg::lse_instr_type'({PROG[i][13:12], PROG[i][11:8], PROG[i][6:0]});
      tick(1);
    end
    prog_we = 1'b0;
    do_reset();
    $display("reset test done");
    t_logic();
    t_hold();
    t_test_mode();
    t_fast();
    t_watchdog();
    t_small();
    print_verdict();
  end
endmodule : tb_ladder_scan_engine
